// ==== rtl/oprl_loader.sv ====
// Purpose: osd page ram loader fed by byte writes from the bus slave
// Assumes: byte stream after slave address, framed by xfer_start/xfer_stop
// Notes:   two-entry buffer in front of the writer; read port for display
//
// Notes on behaviour
// - entry with upper code byte 0x00 is window end, low nibble ignored
// - entries after a window end belong to the next window
// - page ram holds 512 twelve-bit entries, one per code
// - writing frame control bit 3 clears the whole page ram
// - address 0x8000 holds first row skip-line entry of window one
// - after skip-line entry, entries are characters until row or window end
// - entry after a row end is the next row's skip-line entry
// - all-zero entry after row end is skip-line, not window end
// - window end closes both row and window
// - transaction: address low, address high, attribute (page ram addresses only), then codes
// - attribute nibble stored in low bits of every following entry
// - attribute takes no location; codes fill consecutive locations
// - attribute nibble on row and window ends has no display effect
// - entry with upper code byte 0x01 is a row end
// - skip-line entry: bits 7-4 blank lines, bits 3-0 attribute
// - character entry: code in bits 11-4, attribute in bits 3-0
// - a new transaction to a page ram address takes its first data byte as attribute again
`timescale 1ns/1ps
`include "oprl_cfg.svh"
module oprl_loader
  import oprl_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        xfer_start,
  input  wire logic        xfer_stop,
  input  wire logic        in_valid,
  output logic             in_ready,
  input  wire logic [7:0]  in_byte,
  input  wire logic        rd_req,
  input  wire logic [15:0] rd_addr,
  output logic [7:0]       rd_data,
  input  wire logic [8:0]  disp_addr,
  output logic [11:0]      disp_entry,
  output logic [1:0]       disp_kind,
  output logic [3:0]       disp_window,
  output logic [7:0]       frame_control_primary,
  output logic             clearing
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    oprl_phase_e  phase;
    logic [15:0]  addr;
    logic [3:0]   attr;
    logic         attr_seen;
    logic [7:0]   fctl;
    logic         clr;
    logic [8:0]   clr_idx;
    logic [1:0][7:0]  buf_data;
    logic [1:0][15:0] buf_addr;
    logic [1:0][3:0]  buf_attr;
    logic [1:0]   buf_val;
    logic         wr_ptr;
    logic         rd_ptr;
    logic [7:0]   rd_data;
  } oprl_state_s;

  oprl_state_s        st;
  oprl_state_s        next_st;
  oprl_entry_t        ram [0:`OPRL_RAM_DEPTH-1];

  logic               take;
  logic               commit;
  logic               sink_ready;
  logic               is_ram;
  logic [8:0]         ram_idx;
  logic [15:0]        head_addr;

  function automatic logic in_page(input logic [15:0] a);
    in_page = (a >= `OPRL_RAM_BASE) && (a < `OPRL_RAM_BASE + 16'h0200);
  endfunction : in_page

  // ----------------------------------------------------------------
  // byte intake and transaction decode
  // ----------------------------------------------------------------
  assign in_ready = ~st.buf_val[st.wr_ptr];
  assign take     = in_valid & in_ready;

  always_comb begin
    next_st = st;
    if (xfer_start) begin
      next_st.phase     = OPRL_ADDRL;
      next_st.attr_seen = 1'b0;
    end else if (xfer_stop) begin
      next_st.phase = OPRL_IDLE;
    end else if (take) begin
      case (st.phase)
        OPRL_ADDRL: begin
          next_st.addr[7:0] = in_byte;
          next_st.phase     = OPRL_ADDRH;
        end
        OPRL_ADDRH: begin
          next_st.addr[15:8] = in_byte;
          next_st.phase      = OPRL_DATA;
        end
        OPRL_DATA: begin
          if (in_page(st.addr) && !st.attr_seen) begin
            next_st.attr      = in_byte[3:0];
            next_st.attr_seen = 1'b1;
          end else begin
            next_st.buf_data[st.wr_ptr] = in_byte;
            next_st.buf_addr[st.wr_ptr] = st.addr;
            next_st.buf_attr[st.wr_ptr] = st.attr;
            next_st.buf_val[st.wr_ptr]  = 1'b1;
            next_st.wr_ptr              = ~st.wr_ptr;
            next_st.addr                = st.addr + 16'h0001;
          end
        end
        default: next_st.phase = OPRL_IDLE;
      endcase
    end
    // buffer drain, stalled while clearing
    if (commit) begin
      next_st.buf_val[st.rd_ptr] = 1'b0;
      next_st.rd_ptr             = ~st.rd_ptr;
      if (head_addr == `OPRL_FRAME_CTRL) begin
        next_st.fctl = st.buf_data[st.rd_ptr];
        if (st.buf_data[st.rd_ptr][`OPRL_CLEAR_BIT]) begin
          next_st.clr     = 1'b1;
          next_st.clr_idx = 9'h000;
        end
      end
    end
    if (st.clr) begin
      next_st.clr_idx = st.clr_idx + 9'h001;
      if (st.clr_idx == 9'h1FF) begin
        next_st.clr                          = 1'b0;
        next_st.fctl[`OPRL_CLEAR_BIT]        = 1'b0;
      end
    end
    if (rd_req) begin
      next_st.rd_data = (rd_addr == `OPRL_FRAME_CTRL) ? st.fctl :
                        in_page(rd_addr) ? ram[rd_addr[8:0]][11:4] : 8'h00;
    end
    if (reset) begin
      next_st       = '0;
      next_st.fctl  = `OPRL_FRAME_RESET;
      next_st.phase = OPRL_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // page ram write and clear
  // ----------------------------------------------------------------
  assign sink_ready = ~st.clr;
  assign head_addr  = st.buf_addr[st.rd_ptr];
  assign commit     = st.buf_val[st.rd_ptr] & sink_ready & ~reset;
  assign is_ram     = in_page(head_addr);
  assign ram_idx    = head_addr[8:0];

  always_ff @(posedge clk) begin
    if (st.clr) begin
      ram[st.clr_idx] <= 12'h000;
    end else if (commit && is_ram) begin
      ram[ram_idx] <= {st.buf_data[st.rd_ptr], st.buf_attr[st.rd_ptr]};
    end
  end

  // ----------------------------------------------------------------
  // display-side entry classification
  // ----------------------------------------------------------------
  logic [1:0]  kind;
  logic [1:0]  prev_kind;
  logic [3:0]  win;
  oprl_entry_t cur_entry;

  assign cur_entry = ram[disp_addr];

  // 0 skip-line, 1 character, 2 row end, 3 window end
  // parsed from location 0: skip-line codes may equal marker codes
  // window count: number of window ends before this location
  always_comb begin
    logic       want_sl;
    logic [1:0] k;
    logic [1:0] pk;
    logic [3:0] w;
    want_sl   = 1'b1;
    k         = 2'h0;
    pk        = 2'h0;
    w         = 4'h0;
    kind      = 2'h0;
    prev_kind = 2'h0;
    win       = 4'h0;
    for (int i = 0; i < `OPRL_RAM_DEPTH; i++) begin
      if (want_sl) begin
        k       = 2'h0;
        want_sl = 1'b0;
      end else if (ram[i][11:4] == `OPRL_CODE_WE) begin
        k       = 2'h3;
        want_sl = 1'b1;
      end else if (ram[i][11:4] == `OPRL_CODE_RE) begin
        k       = 2'h2;
        want_sl = 1'b1;
      end else begin
        k = 2'h1;
      end
      if (i == int'(disp_addr)) begin
        kind      = k;
        prev_kind = pk;
        win       = w;
      end
      if (k == 2'h3) begin
        w = w + 4'h1;
      end
      pk = k;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      disp_entry  <= 12'h000;
      disp_kind   <= 2'h0;
      disp_window <= 4'h0;
    end else begin
      disp_entry  <= cur_entry;
      disp_kind   <= kind;
      disp_window <= win;
    end
  end

  assign rd_data               = st.rd_data;
  assign frame_control_primary = st.fctl;
  assign clearing              = st.clr;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_clear_start: assert property (@(posedge clk) disable iff (reset)
    commit && head_addr == `OPRL_FRAME_CTRL && st.buf_data[st.rd_ptr][`OPRL_CLEAR_BIT]
    |=> clearing)
    else $error("clear not started");
  a_attr_kept: assert property (@(posedge clk) disable iff (reset)
    commit && is_ram && !st.clr |=> ram[$past(ram_idx)][3:0] == $past(st.buf_attr[st.rd_ptr]))
    else $error("attribute not stored");
  a_no_drop: assert property (@(posedge clk) disable iff (reset)
    in_valid && !in_ready && !st.clr |=> !$stable(st.buf_val))
    else $error("buffer stall without drain");
  a_clear_len: assert property (@(posedge clk) disable iff (reset)
    $rose(clearing) |-> clearing [*8])
    else $error("clear ended early");
  a_addr_step: assert property (@(posedge clk)
    disable iff (reset || xfer_start || xfer_stop)
    take && st.phase == OPRL_DATA && st.attr_seen |=> st.addr == $past(st.addr) + 16'h0001)
    else $error("address did not step");
  a_attr_again: assert property (@(posedge clk) disable iff (reset)
    xfer_start |=> !st.attr_seen)
    else $error("attribute not rearmed");
  a_re_then_sl: assert property (@(posedge clk) disable iff (reset)
    disp_addr != 9'h000 && prev_kind == 2'h2 |=> disp_kind == 2'h0)
    else $error("entry after row end not skip-line");
  a_we_kind: assert property (@(posedge clk) disable iff (reset)
    disp_addr != 9'h000 && (prev_kind == 2'h0 || prev_kind == 2'h1) &&
    cur_entry[11:4] == `OPRL_CODE_WE |=> disp_kind == 2'h3)
    else $error("window end not seen");
endmodule : oprl_loader

// ==== rtl/oprl_cfg.svh ====
// Purpose: constants for the osd page ram loader
// Assumes: bus addresses are 16 bits, data bytes 8 bits
// Notes:   none
`ifndef OPRL_CFG_SVH
`define OPRL_CFG_SVH
`define OPRL_RAM_BASE      16'h8000
`define OPRL_RAM_DEPTH     512
`define OPRL_FRAME_CTRL    16'h8400
`define OPRL_FRAME_RESET   8'h00
`define OPRL_CLEAR_BIT     3
`define OPRL_CODE_WE       8'h00
`define OPRL_CODE_RE       8'h01
`endif

// ==== rtl/oprl_pkg.sv ====
// Purpose: types for the osd page ram loader
// Assumes: nothing
// Notes:   none
package oprl_pkg;
  typedef enum logic [1:0] {
    OPRL_IDLE  = 2'b00,
    OPRL_ADDRL = 2'b01,
    OPRL_ADDRH = 2'b10,
    OPRL_DATA  = 2'b11
  } oprl_phase_e;

  typedef enum logic [1:0] {
    OPRL_ROW_SKIP = 2'b00,
    OPRL_ROW_CHAR = 2'b01
  } oprl_parse_e;

  typedef logic [11:0] oprl_entry_t;
endpackage : oprl_pkg

// ==== sim/oprl_host_model.sv ====
// Purpose: host byte source for the page ram loader
// Assumes: bytes after the slave address, framed by start and stop
// Notes:   released data line shows the inverted last byte
`timescale 1ns/1ps
module oprl_host_model (
  input  wire logic       clk,
  input  wire logic       in_ready,
  output logic            xfer_start,
  output logic            xfer_stop,
  output logic            in_valid,
  output logic [7:0]      in_byte
);
  initial begin
    xfer_start = 1'b0;
    xfer_stop  = 1'b0;
    in_valid   = 1'b0;
    in_byte    = 8'h5A;
  end
  // hold byte until taken, return at the next falling edge
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    in_valid = 1'b1;
    in_byte  = b;
    #1;
    while (in_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      #1;
      n++;
    end
    @(negedge clk);
  endtask : put
  // address low, address high, optional attribute, then codes
  task automatic write(input logic [15:0] a, input bit attr_on, input logic [7:0] attr,
                       input logic [7:0] codes[$]);
    @(negedge clk);
    xfer_start = 1'b1;
    @(negedge clk);
    xfer_start = 1'b0;
    put(a[7:0]);
    put(a[15:8]);
    if (attr_on) put(attr);
    foreach (codes[i]) put(codes[i]);
    in_valid  = 1'b0;
    in_byte   = ~in_byte;
    xfer_stop = 1'b1;
    @(negedge clk);
    xfer_stop = 1'b0;
  endtask : write
endmodule : oprl_host_model

// ==== sim/osd_page_ram_loader_tb_top.sv ====
// Purpose: self-checking bench for the page ram loader
// Assumes: host model drives the byte stream
// Notes:   display port used to read entries back
`timescale 1ns/1ps
`include "oprl_cfg.svh"
module osd_page_ram_loader_tb_top;
  logic clk = 1'b0, reset = 1'b1, rd_req = 1'b0, stalled = 1'b0;
  logic xfer_start, xfer_stop, in_valid, in_ready, clearing;
  logic [7:0] in_byte, rd_data, frame_control_primary;
  logic [15:0] rd_addr = 16'h0000;
  logic [8:0] disp_addr = 9'h000;
  logic [11:0] disp_entry;
  logic [1:0] disp_kind;
  logic [3:0] disp_window;
  int error_cnt = 0, comparisons = 0, n;
  localparam logic [11:0] exp_e [11] = '{12'h205, 12'h025, 12'h035, 12'h015, 12'h005,
    12'h055, 12'h005, 12'h30A, 12'h41A, 12'hFFC, 12'h00C};
  localparam logic [1:0] exp_k [11] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h3, 2'h0,
    2'h1, 2'h1, 2'h3};
  localparam logic [3:0] exp_w [11] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h1,
    4'h1, 4'h1, 4'h1};
  always #10 clk = ~clk;
  oprl_host_model host (.clk(clk), .in_ready(in_ready), .xfer_start(xfer_start),
    .xfer_stop(xfer_stop), .in_valid(in_valid), .in_byte(in_byte));
  oprl_loader uut (.clk(clk), .reset(reset), .xfer_start(xfer_start),
    .xfer_stop(xfer_stop), .in_valid(in_valid), .in_ready(in_ready), .in_byte(in_byte),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data), .disp_addr(disp_addr),
    .disp_entry(disp_entry), .disp_kind(disp_kind), .disp_window(disp_window),
    .frame_control_primary(frame_control_primary), .clearing(clearing));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic show(input logic [8:0] i);
    @(negedge clk);
    disp_addr = i;
    @(negedge clk);
  endtask : show
  task automatic rd(input logic [15:0] a);
    @(negedge clk);
    rd_req  = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_req  = 1'b0;
    rd_addr = ~a;
  endtask : rd
  task automatic test_done();
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    chk(16'(frame_control_primary), 16'(`OPRL_FRAME_RESET));
    host.write(`OPRL_RAM_BASE, 1'b1, 8'hF5, '{8'h20, 8'h02, 8'h03, 8'h01, 8'h00, 8'h05,
      8'h00});
    host.write(`OPRL_RAM_BASE + 16'h0007, 1'b1, 8'h3A, '{8'h30, 8'h41});
    host.write(`OPRL_RAM_BASE + 16'h0009, 1'b1, 8'h0C, '{8'hFF, 8'h00});
    repeat (2) @(negedge clk);
    for (int i = 0; i < 11; i++) begin
      show(9'(i));
      chk(16'(disp_entry), 16'(exp_e[i]));
      chk(16'(disp_kind), 16'(exp_k[i]));
      if (exp_k[i] != 2'd3) chk(16'(disp_window), 16'(exp_w[i]));
    end
    rd(`OPRL_RAM_BASE + 16'h0001);
    chk(16'(rd_data), 16'h0002);
    rd(16'h9000);
    chk(16'(rd_data), 16'h0000);
    fork
      begin
        host.write(`OPRL_FRAME_CTRL, 1'b0, 8'h00, '{8'h18});
        host.write(`OPRL_RAM_BASE + 16'h0001, 1'b1, 8'h07, '{8'h11, 8'h22, 8'h33});
      end
      begin
        n = 0;
        repeat (700) begin
          @(negedge clk);
          if (clearing === 1'b1) n++;
          if (clearing === 1'b1 && in_ready === 1'b0) stalled = 1'b1;
        end
      end
    join
    chk(16'(n), 16'(`OPRL_RAM_DEPTH));
    chk(16'(stalled), 16'h0001);
    chk(16'(frame_control_primary[`OPRL_CLEAR_BIT]), 16'h0000);
    chk(16'(frame_control_primary), 16'h0010);
    rd(`OPRL_FRAME_CTRL);
    chk(16'(rd_data), 16'h0010);
    show(9'd0);
    chk(16'(disp_entry), 16'h0000);
    show(9'd3);
    chk(16'(disp_entry), 16'h0337);
    show(9'd511);
    chk(16'(disp_entry), 16'h0000);
    test_done();
  end
  // tests need about 800 cycles; allow 3000
  initial begin
    #(3000 * 20);
    error_cnt++;
    test_done();
  end
endmodule : osd_page_ram_loader_tb_top
